// File: flash_program_command_control_tb.sv
// testbench: register level scenarios for the flash program sequencer
`timescale 1ns/100ps
`default_nettype none
module flash_program_command_control_tb
  import fpcc_pkg::*;
;
  logic mclk, rst, wr, rd, xtal, stall, soft_reset_trigger, boot;
  logic [7:0] addr, wdata, rdata;
  logic [5:0] tbase;
  int n_errors = 0;
  int samples_checked = 0;
  int soft_reset_trigger_cnt = 0;

  fpcc_seq i_dut (.mclk_i(mclk), .rst_i(rst), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_addr_i(addr), .sfr_wdata_i(wdata), .xtal_ready_i(xtal),
    .sfr_rdata_o(rdata), .cpu_stall_o(stall), .soft_reset_o(soft_reset_trigger),
    .boot_source_select_o(boot), .prog_timebase_field_o(tbase));
  fpcc_cpu_model i_cpu (.mclk_i(mclk), .sfr_rdata_i(rdata), .sfr_wr_o(wr),
    .sfr_rd_o(rd), .sfr_addr_o(addr), .sfr_wdata_o(wdata));

  // 20 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // counts pulse cycles so a stretched reset pulse is caught
  always @(posedge mclk) begin
    if (soft_reset_trigger === 1'b1) soft_reset_trigger_cnt <= soft_reset_trigger_cnt + 1;
  end

  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, string w);
    logic [7:0] v;
    i_cpu.rd(a, v);
    chk(w, e, v);
  endtask : rdchk

  // full command: control, mode, address, data, then the two key bytes
  task automatic cmd(input logic [7:0] ctl, md, ah, al, dt, k2);
    i_cpu.wr(FPCC_ADDR_CTRL, ctl);
    i_cpu.wr(FPCC_ADDR_MODE, md);
    i_cpu.wr(FPCC_ADDR_AHI, ah);
    i_cpu.wr(FPCC_ADDR_ALO, al);
    i_cpu.wr(FPCC_ADDR_DATA, dt);
    i_cpu.wr(FPCC_ADDR_KEY, FPCC_KEY_FIRST);
    i_cpu.wr(FPCC_ADDR_KEY, k2);
  endtask : cmd

  // bounded wait so a stall that never ends cannot hang the run
  task automatic wait_done(input string w);
    int n;
    n = 0;
    #1;
    chk({w, " stall"}, 8'h01, {7'h00, stall});
    while (stall === 1'b1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({w, " done"}, 8'h00, {7'h00, stall});
    @(posedge mclk);
  endtask : wait_done

  task automatic s_reset_clock();
    chk("timebase", 8'h0b, {2'b00, tbase});
    chk("boot", 8'h00, {7'h00, boot});
    rdchk(FPCC_ADDR_CTRL, 8'h00, "ctrl reset");
    rdchk(FPCC_ADDR_CLK1, 8'h0b, "clk1 reset");
    xtal <= 1'b1;
    repeat (4) @(posedge mclk);
    rdchk(FPCC_ADDR_CLK1, 8'h8b, "xtal ready");
    i_cpu.wr(FPCC_ADDR_CLK1, 8'h13);
    @(posedge mclk);
    chk("timebase 20", 8'h13, {2'b00, tbase});
    rdchk(FPCC_ADDR_CLK1, 8'h93, "clk1 ro bit");
  endtask : s_reset_clock

  task automatic s_hidden();
    cmd(8'h80, 8'h05, 8'h00, 8'h03, 8'hff, FPCC_KEY_SECOND);
    rdchk(FPCC_ADDR_DATA, 8'h36, "bound read");
    cmd(8'h80, 8'h04, 8'h00, 8'h03, 8'h30, FPCC_KEY_SECOND);
    cmd(8'h80, 8'h05, 8'h00, 8'h03, 8'h00, FPCC_KEY_SECOND);
    rdchk(FPCC_ADDR_DATA, 8'h30, "bound write");
    cmd(8'h00, 8'h04, 8'h00, 8'h03, 8'h20, FPCC_KEY_SECOND);
    cmd(8'h80, 8'h04, 8'h00, 8'h03, 8'h20, 8'h12);
    i_cpu.wr(FPCC_ADDR_KEY, FPCC_KEY_SECOND);
    cmd(8'h80, 8'h05, 8'h00, 8'h03, 8'h00, FPCC_KEY_SECOND);
    rdchk(FPCC_ADDR_DATA, 8'h30, "no trigger");
  endtask : s_hidden

  task automatic s_flash();
    cmd(8'h80, 8'h03, 8'h30, 8'h00, 8'hff, FPCC_KEY_SECOND);
    wait_done("erase");
    cmd(8'h80, 8'h02, 8'h30, 8'h00, 8'h5a, FPCC_KEY_SECOND);
    wait_done("prog");
    rdchk(FPCC_ADDR_CTRL, 8'h80, "prog ok");
    cmd(8'h80, 8'h01, 8'h30, 8'h00, 8'h00, FPCC_KEY_SECOND);
    wait_done("read");
    rdchk(FPCC_ADDR_DATA, 8'h5a, "read back");
    cmd(8'h80, 8'h82, 8'h30, 8'h01, 8'h3c, FPCC_KEY_SECOND);
    wait_done("prog inc");
    cmd(8'h80, 8'h81, 8'h30, 8'h01, 8'h00, FPCC_KEY_SECOND);
    wait_done("read inc");
    rdchk(FPCC_ADDR_DATA, 8'h3c, "read inc back");
    cmd(8'h80, 8'h02, 8'h2f, 8'hff, 8'ha5, FPCC_KEY_SECOND);
    repeat (4) begin
      #1;
      chk("outside stall", 8'h00, {7'h00, stall});
      @(posedge mclk);
    end
    rdchk(FPCC_ADDR_CTRL, 8'h80, "outside fail");
    cmd(8'h80, 8'h03, 8'h3a, 8'h00, 8'hff, FPCC_KEY_SECOND);
    #1;
    chk("erase above stall", 8'h00, {7'h00, stall});
    @(posedge mclk);
    cmd(8'h80, 8'h07, 8'h30, 8'h00, 8'h00, FPCC_KEY_SECOND);
    rdchk(FPCC_ADDR_CTRL, 8'h90, "unknown mode");
  endtask : s_flash

  task automatic s_fail_reset();
    int c0;
    cmd(8'h80, 8'h05, 8'h00, 8'h04, 8'h00, FPCC_KEY_SECOND);
    rdchk(FPCC_ADDR_CTRL, 8'h90, "bad index");
    rdchk(FPCC_ADDR_CTRL, 8'h90, "fail holds");
    cmd(8'h80, 8'h05, 8'h00, 8'h03, 8'h00, FPCC_KEY_SECOND);
    rdchk(FPCC_ADDR_CTRL, 8'h80, "fail cleared");
    c0 = soft_reset_trigger_cnt;
    i_cpu.wr(FPCC_ADDR_CTRL, 8'he0);
    repeat (2) @(posedge mclk);
    chk("reset pulses", 8'h01, 8'(soft_reset_trigger_cnt - c0));
    chk("boot loader", 8'h01, {7'h00, boot});
    rdchk(FPCC_ADDR_CTRL, 8'hc0, "soft_reset_trigger cleared");
    i_cpu.wr(FPCC_ADDR_CTRL, 8'h00);
    @(posedge mclk);
    chk("boot main", 8'h00, {7'h00, boot});
  endtask : s_fail_reset

  // main sequence; reset held three cycles
  initial begin
    rst = 1'b1;
    xtal = 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    s_reset_clock();
    s_hidden();
    s_flash();
    s_fail_reset();
    stop_test();
  end

  // watchdog: the whole sequence needs well under 4000 cycles
  initial begin
    #(4000 * 50);
    n_errors++;
    stop_test();
  end
endmodule : flash_program_command_control_tb
`default_nettype wire

// File: fpcc_cpu_model.sv
// partner model: cpu side of the special register bus, one access at a time
`timescale 1ns/100ps
`default_nettype none
module fpcc_cpu_model (
  input wire logic mclk_i,
  input wire logic [7:0] sfr_rdata_i,
  output logic sfr_wr_o,
  output logic sfr_rd_o,
  output logic [7:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o
);
  // bus idles from time zero so reset sees no stray strobe
  initial begin
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_addr_o = 8'h00;
    sfr_wdata_o = 8'h00;
  end

  // write held for one edge; released lines show inverted junk afterwards
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_o <= a;
    sfr_wdata_o <= d;
    sfr_wr_o <= 1'b1;
    @(posedge mclk_i);
    sfr_wr_o <= 1'b0;
    sfr_addr_o <= ~a;
    sfr_wdata_o <= ~d;
    @(posedge mclk_i);
  endtask : wr

  // read data is registered twice and settles one edge after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_o <= a;
    sfr_rd_o <= 1'b1;
    @(posedge mclk_i);
    sfr_rd_o <= 1'b0;
    sfr_addr_o <= ~a;
    repeat (2) @(posedge mclk_i);
    #1;
    d = sfr_rdata_i;
    @(posedge mclk_i);
  endtask : rd
endmodule : fpcc_cpu_model
`default_nettype wire

// File: fpcc_flash_if.sv
// interface: sequencer to flash array command and answer signals
`timescale 1ns/100ps
`default_nettype none
interface fpcc_flash_if;
  logic req;
  logic [1:0] op;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output op, output addr, output wdata,
               input done, input rdata);
  modport mem (input req, input op, input addr, input wdata,
               output done, output rdata);
endinterface : fpcc_flash_if
`default_nettype wire

// File: fpcc_flash_mem.sv
// module: small flash array model memory with timed program, erase and read
`timescale 1ns/100ps
`default_nettype none
module fpcc_flash_mem
  import fpcc_pkg::*;
#(
  parameter int AW = 14,
  parameter int PAGE_AW = 9
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  fpcc_flash_if.mem fl
);
  initial begin
    if (PAGE_AW >= AW || AW > 16) $error("fpcc_flash_mem: bad widths");
  end
  logic [7:0] mem_r [0:(1<<AW)-1];
  logic [7:0] rdata_r;
  logic done_r;
  logic busy_r;
  logic [15:0] cnt_r;
  logic [AW-1:0] a;
  assign a = fl.addr[AW-1:0];
  assign fl.rdata = rdata_r;
  assign fl.done = done_r;

  // operation timer; one request in flight at a time
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      cnt_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && fl.req) begin
        busy_r <= 1'b1;
        cnt_r <= 16'(FPCC_OP_CYC);
      end else if (busy_r) begin
        if (cnt_r <= 16'h0001) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end

  // array access at completion; erase clears the whole page to ones
  always_ff @(posedge mclk_i) begin
    if (busy_r && cnt_r <= 16'h0001) begin
      case (fl.op)
        2'h1: mem_r[a] <= mem_r[a] & fl.wdata;
        2'h2: begin
          for (int i = 0; i < (1 << PAGE_AW); i++) begin
            mem_r[{a[AW-1:PAGE_AW], PAGE_AW'(i)}] <= 8'hff;
          end
        end
        default: ;
      endcase
    end
  end

  // registered read data
  always_ff @(posedge mclk_i) begin
    if (rst_i) rdata_r <= FPCC_DATA_RST;
    else if (busy_r && cnt_r <= 16'h0001) rdata_r <= mem_r[a];
  end
endmodule : fpcc_flash_mem
`default_nettype wire

// File: fpcc_pkg.sv
// package: register map, field layout and timing constants of the flash sequencer
// Function
// - operation starts only on key 0x46 then 0xb9 with global enable set
// - global enable clear blocks all program, erase and read operations
// - control bit 6 picks boot source for next reset: 0 main, 1 loader
// - writing 1 to bit 5 fires soft reset; hardware clears it
// - bit 4 reads 1 when last command failed, 0 on success
// - time-base field resets to 00-1011, a 12 MHz oscillator
// - writable region spans low-boundary times 256 up to loader start minus one
// - hidden read mode with key places low-boundary value in data port
// - hidden write mode with key loads data port into low-boundary
// - valid key stalls the cpu until the flash operation completes
// - mode register selects standby, read, program, erase and hidden modes; 0x81 and 0x82 act as plain read and program
// - program or erase outside writable region is ignored, nothing done
// - clock control bit 7 is a read-only crystal ready flag
package fpcc_pkg;
  localparam logic [7:0] FPCC_ADDR_CLK1 = 8'hbf;
  localparam logic [7:0] FPCC_ADDR_DATA = 8'he2;
  localparam logic [7:0] FPCC_ADDR_AHI = 8'he3;
  localparam logic [7:0] FPCC_ADDR_ALO = 8'he4;
  localparam logic [7:0] FPCC_ADDR_MODE = 8'he5;
  localparam logic [7:0] FPCC_ADDR_KEY = 8'he6;
  localparam logic [7:0] FPCC_ADDR_CTRL = 8'he7;
  localparam logic [7:0] FPCC_KEY_FIRST = 8'h46;
  localparam logic [7:0] FPCC_KEY_SECOND = 8'hb9;
  localparam int FPCC_BIT_EN = 7;
  localparam int FPCC_BIT_BOOT = 6;
  localparam int FPCC_BIT_SOFT_RESET_TRIGGER = 5;
  localparam int FPCC_BIT_FAIL = 4;
  localparam int FPCC_BIT_XTAL = 7;
  localparam logic [5:0] FPCC_TB_RST = 6'h0b;
  localparam logic [7:0] FPCC_LB_RST = 8'h36;
  localparam logic [7:0] FPCC_DATA_RST = 8'hff;
  localparam logic [7:0] FPCC_LB_INDEX = 8'h03;
  localparam logic [7:0] FPCC_HIDDEN_AHI = 8'h00;
  localparam logic [15:0] FPCC_LOADER_START = 16'h3a00;
  localparam int FPCC_CLK_MHZ = 20;
  // per-byte operation time in oscillator microseconds, scaled by clock rate
  localparam int FPCC_OP_US = 2;
  localparam int FPCC_OP_CYC = (FPCC_OP_US * FPCC_CLK_MHZ < 1) ? 1 :
                               FPCC_OP_US * FPCC_CLK_MHZ;
  typedef enum logic [7:0] {
    FPCC_MODE_STANDBY = 8'h00,
    FPCC_MODE_READ = 8'h01,
    FPCC_MODE_PROG = 8'h02,
    FPCC_MODE_ERASE = 8'h03,
    FPCC_MODE_HWRITE = 8'h04,
    FPCC_MODE_HREAD = 8'h05,
    FPCC_MODE_CRC = 8'h80,
    FPCC_MODE_READ_INC = 8'h81,
    FPCC_MODE_PROG_INC = 8'h82
  } fpcc_mode_t;
endpackage : fpcc_pkg

// File: fpcc_seq.sv
// module: flash program command sequencer with key detector and special regs
`timescale 1ns/100ps
`default_nettype none
module fpcc_seq
  import fpcc_pkg::*;
#(
  parameter logic [15:0] LOADER_START = FPCC_LOADER_START
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic xtal_ready_i,
  output logic [7:0] sfr_rdata_o,
  output logic cpu_stall_o,
  output logic soft_reset_o,
  output logic boot_source_select_o,
  output logic [5:0] prog_timebase_field_o
);
  initial begin
    if (LOADER_START[7:0] != 8'h00) $error("fpcc_seq: loader start unaligned");
  end
  typedef enum logic [1:0] {
    FPCC_ST_IDLE = 2'b00,
    FPCC_ST_ARMED = 2'b01,
    FPCC_ST_BUSY = 2'b10
  } fpcc_state_t;

  fpcc_flash_if fl ();
  fpcc_flash_mem u_mem (.mclk_i(mclk_i), .rst_i(rst_i), .fl(fl.mem));

  fpcc_state_t state_r;
  logic flash_op_enable_r, boot_r, soft_reset_trigger_r, fail_r;
  logic [5:0] tb_r;
  logic [7:0] data_r, ahi_r, alo_r, mode_r, lb_r, rdata_r;
  logic req_r;
  logic [1:0] op_r;
  logic [2:0] xtal_sync_r;
  logic xtal_r;
  logic wr_key, key_go, in_region, hid_ok;
  logic [15:0] addr;

  assign wr_key = sfr_wr_i && sfr_addr_i == FPCC_ADDR_KEY;
  assign addr = {ahi_r, alo_r};
  assign in_region = addr >= {lb_r, 8'h00} && addr < LOADER_START;
  assign hid_ok = ahi_r == FPCC_HIDDEN_AHI && alo_r == FPCC_LB_INDEX;
  // trigger only with the enable set and the second key byte following
  assign key_go = wr_key && state_r == FPCC_ST_ARMED &&
                  sfr_wdata_i == FPCC_KEY_SECOND && flash_op_enable_r;
  assign fl.req = req_r;
  assign fl.op = op_r;
  assign fl.addr = addr;
  assign fl.wdata = data_r;

  // key detector and command engine
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= FPCC_ST_IDLE;
      req_r <= 1'b0;
      op_r <= 2'h0;
      fail_r <= 1'b0;
      cpu_stall_o <= 1'b0;
    end else begin
      req_r <= 1'b0;
      case (state_r)
        FPCC_ST_IDLE: begin
          if (wr_key && sfr_wdata_i == FPCC_KEY_FIRST && flash_op_enable_r)
            state_r <= FPCC_ST_ARMED;
        end
        FPCC_ST_ARMED: begin
          if (key_go) begin
            case (mode_r)
              FPCC_MODE_READ, FPCC_MODE_READ_INC: begin
                op_r <= 2'h0;
                req_r <= 1'b1;
                state_r <= FPCC_ST_BUSY;
                cpu_stall_o <= 1'b1;
              end
              FPCC_MODE_PROG, FPCC_MODE_PROG_INC, FPCC_MODE_ERASE: begin
                // out-of-region writes are dropped without any effect
                if (in_region) begin
                  op_r <= (mode_r == FPCC_MODE_ERASE) ? 2'h2 : 2'h1;
                  req_r <= 1'b1;
                  state_r <= FPCC_ST_BUSY;
                  cpu_stall_o <= 1'b1;
                end else begin
                  state_r <= FPCC_ST_IDLE;
                end
              end
              FPCC_MODE_HWRITE, FPCC_MODE_HREAD: begin
                // hidden page completes in one cycle; no array timing
                fail_r <= !hid_ok;
                state_r <= FPCC_ST_IDLE;
              end
              default: begin
                fail_r <= 1'b1;
                state_r <= FPCC_ST_IDLE;
              end
            endcase
          end else if (sfr_wr_i) begin
            state_r <= FPCC_ST_IDLE;
          end
        end
        FPCC_ST_BUSY: begin
          if (fl.done) begin
            fail_r <= 1'b0;
            cpu_stall_o <= 1'b0;
            state_r <= FPCC_ST_IDLE;
          end
        end
        default: state_r <= FPCC_ST_IDLE;
      endcase
    end
  end

  // control register; soft reset self-clears one cycle after the write
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flash_op_enable_r <= 1'b0;
      boot_r <= 1'b0;
      soft_reset_trigger_r <= 1'b0;
    end else if (sfr_wr_i && sfr_addr_i == FPCC_ADDR_CTRL) begin
      flash_op_enable_r <= sfr_wdata_i[FPCC_BIT_EN];
      boot_r <= sfr_wdata_i[FPCC_BIT_BOOT];
      soft_reset_trigger_r <= sfr_wdata_i[FPCC_BIT_SOFT_RESET_TRIGGER];
    end else begin
      soft_reset_trigger_r <= 1'b0;
    end
  end

  // address, mode and time-base registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ahi_r <= 8'h00;
      alo_r <= 8'h00;
      mode_r <= FPCC_MODE_STANDBY;
      tb_r <= FPCC_TB_RST;
    end else if (sfr_wr_i) begin
      case (sfr_addr_i)
        FPCC_ADDR_AHI: ahi_r <= sfr_wdata_i;
        FPCC_ADDR_ALO: alo_r <= sfr_wdata_i;
        FPCC_ADDR_MODE: mode_r <= sfr_wdata_i;
        FPCC_ADDR_CLK1: tb_r <= sfr_wdata_i[5:0];
        default: ;
      endcase
    end
  end

  // data port; flash and hidden reads land here
  always_ff @(posedge mclk_i) begin
    if (rst_i) data_r <= FPCC_DATA_RST;
    else if (state_r == FPCC_ST_BUSY && fl.done && op_r == 2'h0)
      data_r <= fl.rdata;
    else if (key_go && mode_r == FPCC_MODE_HREAD && hid_ok)
      data_r <= lb_r;
    else if (sfr_wr_i && sfr_addr_i == FPCC_ADDR_DATA) data_r <= sfr_wdata_i;
  end

  // hidden low-boundary register
  always_ff @(posedge mclk_i) begin
    if (rst_i) lb_r <= FPCC_LB_RST;
    else if (key_go && mode_r == FPCC_MODE_HWRITE && hid_ok)
      lb_r <= data_r;
  end

  // crystal ready pin: three flops, change taken when last two agree
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      xtal_sync_r <= 3'b000;
      xtal_r <= 1'b0;
    end else begin
      xtal_sync_r <= {xtal_sync_r[1:0], xtal_ready_i};
      if (xtal_sync_r[1] == xtal_sync_r[2]) xtal_r <= xtal_sync_r[2];
    end
  end

  // registered read mux; unmapped addresses read zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) rdata_r <= 8'h00;
    else if (sfr_rd_i) begin
      case (sfr_addr_i)
        FPCC_ADDR_CTRL: rdata_r <= {flash_op_enable_r, boot_r, soft_reset_trigger_r,
                                    fail_r, 4'h0};
        FPCC_ADDR_CLK1: rdata_r <= {xtal_r, 1'b0, tb_r};
        FPCC_ADDR_DATA: rdata_r <= data_r;
        FPCC_ADDR_AHI: rdata_r <= ahi_r;
        FPCC_ADDR_ALO: rdata_r <= alo_r;
        FPCC_ADDR_MODE: rdata_r <= mode_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  // outputs straight from flops
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      soft_reset_o <= 1'b0;
      boot_source_select_o <= 1'b0;
      prog_timebase_field_o <= FPCC_TB_RST;
      sfr_rdata_o <= 8'h00;
    end else begin
      soft_reset_o <= soft_reset_trigger_r;
      boot_source_select_o <= boot_r;
      prog_timebase_field_o <= tb_r;
      sfr_rdata_o <= rdata_r;
    end
  end

  // a stall can only start on a key seen with the enable set
  a_key_needs_en: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !flash_op_enable_r |=> !$rose(cpu_stall_o))
    else $error("trigger without enable");
  a_stall_on_op: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (key_go && mode_r == FPCC_MODE_PROG && in_region) |=> cpu_stall_o)
    else $error("no stall after program trigger");
  a_no_op_outside: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (key_go && mode_r == FPCC_MODE_ERASE && !in_region) |=> !req_r)
    else $error("erase outside region issued");
  a_soft_reset_trigger_clears: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (soft_reset_trigger_r && !sfr_wr_i) |=> !soft_reset_trigger_r)
    else $error("soft reset not cleared");
  a_lb_write: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (key_go && mode_r == FPCC_MODE_HWRITE && hid_ok) |=>
    lb_r == $past(data_r))
    else $error("low bound not written");
  a_lb_read: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (key_go && mode_r == FPCC_MODE_HREAD && hid_ok) |=>
    data_r == $past(lb_r))
    else $error("low bound not read");
  // completion edges leave idle behind them, so only idle-to-idle is held
  a_fail_stable: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state_r == FPCC_ST_IDLE && $past(state_r) == FPCC_ST_IDLE) |->
    $stable(fail_r))
    else $error("fail flag changed idle");
  a_stall_ends: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    $rose(cpu_stall_o) |-> ##[1:200] !cpu_stall_o)
    else $error("stall too long");
  a_boot_follow: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (sfr_wr_i && sfr_addr_i == FPCC_ADDR_CTRL) |-> ##2
    boot_source_select_o == $past(sfr_wdata_i[FPCC_BIT_BOOT], 2))
    else $error("boot select wrong");
  c_prog: cover property (@(posedge mclk_i) key_go && mode_r == FPCC_MODE_PROG);
  c_hread: cover property (@(posedge mclk_i) key_go && mode_r == FPCC_MODE_HREAD);
  c_erase_out: cover property (@(posedge mclk_i)
    key_go && mode_r == FPCC_MODE_ERASE && !in_region);
endmodule : fpcc_seq
`default_nettype wire
